// ### common/dmach_pkg.sv
`default_nettype none
package dmach_pkg;

  // ****************************************************************
  // Register indices (byte address on APB is four times the index)
  // ****************************************************************
  localparam logic [31:0] IDX_CH0_PROGRESS   = 32'h5000360e;
  localparam logic [31:0] IDX_SRC_START_LOW  = 32'h50003610;
  localparam logic [31:0] IDX_SRC_START_HIGH = 32'h50003612;
  localparam logic [31:0] IDX_DST_START_LOW  = 32'h50003614;
  localparam logic [31:0] IDX_DST_START_HIGH = 32'h50003616;
  localparam logic [31:0] IDX_MATCH_COUNT    = 32'h50003618;
  localparam logic [31:0] IDX_ITEM_COUNT     = 32'h5000361a;
  localparam logic [31:0] IDX_CONTROL        = 32'h5000361c;
  localparam logic [31:0] IDX_PROGRESS       = 32'h5000361e;

  // Only these low index bits are decoded
  localparam int unsigned DEC_W = 12;

  // ****************************************************************
  // Reset value and control write mask
  // ****************************************************************
  localparam logic [15:0] RST_REG16   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK  = 16'h3fff;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int unsigned BIT_RUN      = 0;
  localparam int unsigned BIT_SIZE_LO  = 1;
  localparam int unsigned BIT_IRQ_EN   = 3;
  localparam int unsigned BIT_PTRIG    = 4;
  localparam int unsigned BIT_DST_STEP = 5;
  localparam int unsigned BIT_SRC_STEP = 6;
  localparam int unsigned BIT_RING     = 7;
  localparam int unsigned BIT_RANK_LO  = 8;
  localparam int unsigned BIT_YIELD    = 11;
  localparam int unsigned BIT_FILL     = 12;
  localparam int unsigned BIT_EDGE     = 13;

  // ****************************************************************
  // Item sizes
  // ****************************************************************
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef struct packed {
    logic [1:0] reserved;
    logic       edge_trig;
    logic       fill;
    logic       yield;
    logic [2:0] channel_rank;
    logic       ring;
    logic       src_step_en;
    logic       dst_step_en;
    logic       periph_trigger;
    logic       irq_en;
    logic [1:0] item_size;
    logic       run;
  } dmach_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmach_bus_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_ARB   = 3'b010,
    ST_READ  = 3'b011,
    ST_WRITE = 3'b100,
    ST_GAP   = 3'b101
  } dmach_state_t;

endpackage

`default_nettype wire

// ### tb/dmach_channel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dmach_channel_asserts (
  input wire logic                  MCLK,
  input wire logic                  RSTN,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PREADY,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PSLVERR,
  input wire dmach_pkg::dmach_bus_t BUS_CMD,
  input wire logic                  BUS_READY,
  input wire logic [31:0]           BUS_RDATA,
  input wire logic                  IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // ****************************************************************
  // Register port
  // ****************************************************************
  property p_ready; PSEL && !PENABLE |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_hi; PREADY && !PSLVERR |-> PRDATA[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  // ****************************************************************
  // Bus master and interrupt
  // ****************************************************************
  property p_irq_pulse; IRQ |=> !IRQ; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
  property p_irq_src;
    IRQ |-> $past(BUS_CMD.valid && BUS_CMD.write && BUS_READY);
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("irq not on store");
  property p_rd_wr;
    BUS_CMD.valid && !BUS_CMD.write && BUS_READY |=> BUS_CMD.valid &&
      BUS_CMD.write && BUS_CMD.wdata == $past(BUS_RDATA);
  endproperty
  a_rd_wr: assert property (p_rd_wr)
    else $error("no store of read data");
  property p_hold;
    BUS_CMD.valid && !BUS_READY |=> $stable(BUS_CMD);
  endproperty
  a_hold: assert property (p_hold)
    else $error("command moved in stall");
  property p_drop;
    BUS_CMD.valid && BUS_CMD.write && BUS_READY |=> !BUS_CMD.valid;
  endproperty
  a_drop: assert property (p_drop) else $error("no gap after store");
  property p_size; BUS_CMD.valid |-> BUS_CMD.size != 2'h3; endproperty
  a_size: assert property (p_size) else $error("reserved size");
endmodule
`default_nettype wire

// ### tb/dmach_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmach_mem_model (
  input  wire logic                  MCLK,
  input  wire logic                  RSTN,
  input  wire dmach_pkg::dmach_bus_t BUS_CMD,
  input  wire logic [1:0]            WAIT_N,
  output logic                       BUS_READY,
  output logic [31:0]                BUS_RDATA
);
  logic [1:0] waited;
  logic       hit;
  assign hit = BUS_CMD.valid && !BUS_READY && waited == WAIT_N;
  // Ready is one cycle per beat so a held command never completes twice
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      waited <= 2'h0;
      BUS_READY <= 1'b0;
    end else begin
      waited <= (BUS_CMD.valid && !BUS_READY && !hit) ? waited + 2'h1 : 2'h0;
      BUS_READY <= hit;
    end
  end
  // Outside a read answer the data toggles, so stale values never match
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      BUS_RDATA <= 32'h0;
    end else if (hit && !BUS_CMD.write) begin
      BUS_RDATA <= {BUS_CMD.addr[15:0], ~BUS_CMD.addr[15:0]};
    end else begin
      BUS_RDATA <= ~BUS_RDATA;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic MCLK, RSTN, PSEL, PENABLE, PWRITE, PERIPH_REQ, CH0_BUS_REQ, e, lk;
  logic PREADY, PSLVERR, BUS_READY, BUS_LOCK, BUS_REQ, IRQ;
  logic [31:0] PADDR, PWDATA, PRDATA, BUS_RDATA, r;
  logic [2:0] CH0_RANK;
  logic [1:0] wait_n;
  dmach_pkg::dmach_bus_t BUS_CMD;
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  int n_rd, irqs, n_fail, compares;
  localparam logic [31:0] SRC = 32'h00012000;
  localparam logic [31:0] DST = 32'h00013000;
  always #10 MCLK = ~MCLK;
  dmach_channel DUT (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(4'hf), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .PERIPH_REQ(PERIPH_REQ), .CH0_BUS_REQ(CH0_BUS_REQ),
    .CH0_RANK(CH0_RANK), .CH0_PROGRESS(16'h1234), .BUS_CMD(BUS_CMD),
    .BUS_READY(BUS_READY), .BUS_RDATA(BUS_RDATA), .BUS_LOCK(BUS_LOCK),
    .BUS_REQ(BUS_REQ), .IRQ(IRQ));
  dmach_mem_model u_mem (.MCLK(MCLK), .RSTN(RSTN), .BUS_CMD(BUS_CMD),
    .WAIT_N(wait_n), .BUS_READY(BUS_READY), .BUS_RDATA(BUS_RDATA));
  // ****************************************************************
  // Bus log and helpers
  // ****************************************************************
  always @(posedge MCLK) begin
    if (RSTN === 1'b1 && BUS_CMD.valid === 1'b1 && BUS_READY === 1'b1) begin
      if (BUS_CMD.write) begin
        wa.push_back(BUS_CMD.addr);
        wd.push_back(BUS_CMD.wdata);
      end else begin
        n_rd++;
      end
    end
    if (IRQ === 1'b1) irqs++;
    if (BUS_LOCK === 1'b1) lk = 1'b1;
  end
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    n_fail++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    complete_run;
  endtask
  task automatic apb(input logic w, input logic [31:0] idx,
                     input logic [15:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= idx << 2;
    PWDATA <= {16'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (PREADY !== 1'b1) tmo;
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  // Settle cycles let the run clear and the interrupt land
  task automatic wait_wr(input int n);
    for (int k = 0; k < 400 && wa.size() < n; k++) @(posedge MCLK);
    if (wa.size() < n) tmo;
    repeat (4) @(posedge MCLK);
  endtask
  task automatic go(input logic [15:0] c, input logic [15:0] n,
                    input logic [15:0] m);
    apb(1'b1, dmach_pkg::IDX_ITEM_COUNT, n);
    apb(1'b1, dmach_pkg::IDX_MATCH_COUNT, m);
    wa.delete();
    wd.delete();
    n_rd = 0;
    irqs = 0;
    lk = 1'b0;
    apb(1'b1, dmach_pkg::IDX_CONTROL, c);
  endtask
  task automatic verify(input int n, input int ss, input int ds,
                        input int sz, input logic fill);
    chk(32'(wa.size()), 32'(n));
    chk(32'(n_rd), fill ? 32'h1 : 32'(n));
    for (int i = 0; i < n && i < wa.size(); i++) begin
      chk(wa[i], DST + 32'(i * ds * sz));
      chk(wd[i], pat(SRC + 32'((fill ? 0 : i) * ss * sz)));
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, dmach_pkg::IDX_CH0_PROGRESS + 32'(2 * i), 16'h0);
      chk(r, i == 0 ? 32'h1234 : 32'h0);
    end
    apb(1'b1, dmach_pkg::IDX_SRC_START_LOW, SRC[15:0]);
    apb(1'b1, dmach_pkg::IDX_SRC_START_HIGH, SRC[31:16]);
    apb(1'b1, dmach_pkg::IDX_DST_START_LOW, DST[15:0]);
    apb(1'b1, dmach_pkg::IDX_DST_START_HIGH, DST[31:16]);
    apb(1'b0, dmach_pkg::IDX_SRC_START_HIGH, 16'h0);
    chk(r, {16'h0, SRC[31:16]});
    apb(1'b0, dmach_pkg::IDX_DST_START_LOW, 16'h0);
    chk(r, {16'h0, DST[15:0]});
    apb(1'b1, dmach_pkg::IDX_CONTROL, 16'hc000);
    apb(1'b0, dmach_pkg::IDX_CONTROL, 16'h0);
    chk(r, 32'h0);
    apb(1'b1, dmach_pkg::IDX_PROGRESS, 16'h0055);
    apb(1'b0, dmach_pkg::IDX_PROGRESS, 16'h0);
    chk(r, 32'h0);
    apb(1'b0, dmach_pkg::IDX_CONTROL + 32'h20, 16'h0);
    chk({31'h0, e}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_copy;
    wait_n <= 2'h2;
    go(16'h006d, 16'h2, 16'h1);
    wait_wr(3);
    verify(3, 1, 1, 4, 1'b0);
    chk(32'(irqs), 32'h1);
    chk({31'h0, lk}, 32'h1);
    apb(1'b0, dmach_pkg::IDX_CONTROL, 16'h0);
    chk(r, 32'h006c);
    apb(1'b0, dmach_pkg::IDX_PROGRESS, 16'h0);
    chk(r, 32'h0);
    wait_n <= 2'h0;
    $display("test copy done");
  endtask
  task automatic t_sizes;
    for (int s = 0; s < 2; s++) begin
      go(16'h0021 | 16'(s << 1), 16'h1, 16'h0);
      wait_wr(2);
      verify(2, 0, 1, 1 << s, 1'b0);
      chk(32'(irqs), 32'h0);
    end
    $display("test sizes done");
  endtask
  task automatic t_fill;
    go(16'h1065, 16'h2, 16'h3);
    repeat (3) @(posedge MCLK);
    CH0_BUS_REQ <= 1'b1;
    CH0_RANK <= 3'h7;
    wait_wr(3);
    verify(3, 1, 1, 4, 1'b1);
    CH0_BUS_REQ <= 1'b0;
    $display("test fill done");
  endtask
  task automatic t_arb;
    CH0_BUS_REQ <= 1'b1;
    CH0_RANK <= 3'h3;
    go(16'h0b05, 16'h0, 16'h1);
    repeat (20) @(posedge MCLK);
    chk(32'(wa.size()), 32'h0);
    chk({31'h0, BUS_REQ}, 32'h1);
    CH0_RANK <= 3'h2;
    wait_wr(1);
    verify(1, 0, 0, 4, 1'b0);
    chk({31'h0, lk}, 32'h0);
    CH0_BUS_REQ <= 1'b0;
    $display("test arbitration done");
  endtask
  task automatic t_periph;
    go(16'h0015, 16'h1, 16'h5);
    repeat (10) @(posedge MCLK);
    chk(32'(wa.size()), 32'h0);
    PERIPH_REQ <= 1'b1;
    wait_wr(2);
    verify(2, 0, 0, 4, 1'b0);
    // Request stays high: only a fresh rising edge may start an item
    go(16'h20b5, 16'h1, 16'h5);
    repeat (10) @(posedge MCLK);
    chk(32'(wa.size()), 32'h0);
    chk({31'h0, BUS_REQ}, 32'h0);
    for (int k = 1; k < 4; k++) begin
      PERIPH_REQ <= 1'b0;
      @(posedge MCLK);
      PERIPH_REQ <= 1'b1;
      wait_wr(k);
    end
    PERIPH_REQ <= 1'b0;
    chk(wa[1], DST + 32'h4);
    chk(wa[2], DST);
    apb(1'b0, dmach_pkg::IDX_CONTROL, 16'h0);
    chk(r, 32'h20b5);
    apb(1'b0, dmach_pkg::IDX_PROGRESS, 16'h0);
    chk(r, 32'h1);
    apb(1'b1, dmach_pkg::IDX_CONTROL, 16'h0);
    apb(1'b0, dmach_pkg::IDX_PROGRESS, 16'h0);
    chk(r, 32'h0);
    $display("test peripheral done");
  endtask
  initial begin
    MCLK = 1'b0;
    RSTN = 1'b0;
    {PSEL, PENABLE, PWRITE, PERIPH_REQ, CH0_BUS_REQ, lk} = 6'h0;
    PADDR = 32'h0;
    PWDATA = 32'h0;
    CH0_RANK = 3'h0;
    wait_n = 2'h0;
    repeat (8) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    t_regs;
    t_copy;
    t_sizes;
    t_fill;
    t_arb;
    t_periph;
    complete_run;
  end
endmodule
bind dmach_channel dmach_channel_asserts u_chk (.MCLK(MCLK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PRDATA(PRDATA),
  .PSLVERR(PSLVERR), .BUS_CMD(BUS_CMD), .BUS_READY(BUS_READY),
  .BUS_RDATA(BUS_RDATA), .IRQ(IRQ));
`default_nettype wire

// ### verilog/dmach_channel.sv
// How it works
// RL1: Read-only progress count, cleared on completion
// RL2: Addresses formed from progress count, steps, size
// RL3: Source start held as two 16-bit halves
// RL4: Destination start held as two 16-bit halves
// RL5: Interrupt when match equals count before increment
// RL6: Interrupt only while allow bit set
// RL7: Transfers programmed count plus one items
// RL8: Edge select picks level or rising-edge requests
// RL9: Fill mode reads source once, writes all
// RL10: Fill transfer is never pre-empted
// RL11: Software avoids fill with peripheral trigger
// RL12: Blocking mode copies back to back, locks bus
// RL13: Yield mode waits one cycle after store
// RL14: Three-bit rank decides bus grant
// RL15: Equal rank: lower channel wins
// RL16: Normal mode stops and clears run bit
// RL17: Ring mode with peripheral trigger restarts and keeps run set
// RL18: Source step advances by item size
// RL19: Destination step advances by item size
// RL20: Peripheral trigger waits for request per item
// RL21: Item size decode 1, 2, 4 bytes
// RL22: Channel runs only while run bit set
// RL23: Each item is bus read then bus write; in fill mode, items after the first are a bus write only
// RL24: Reserved control bits read zero
`timescale 1ns/1ps
`default_nettype none

module dmach_channel (
  input  wire logic                 MCLK,
  input  wire logic                 RSTN,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [31:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  input  wire logic [3:0]           PSTRB,
  output logic                      PREADY,
  output logic [31:0]               PRDATA,
  output logic                      PSLVERR,
  input  wire logic                 PERIPH_REQ,
  input  wire logic                 CH0_BUS_REQ,
  input  wire logic [2:0]           CH0_RANK,
  input  wire logic [15:0]          CH0_PROGRESS,
  output dmach_pkg::dmach_bus_t     BUS_CMD,
  input  wire logic                 BUS_READY,
  input  wire logic [31:0]          BUS_RDATA,
  output logic                      BUS_LOCK,
  output logic                      BUS_REQ,
  output logic                      IRQ
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  localparam int unsigned DEC_IDX = dmach_pkg::DEC_W;

  logic [15:0]             src_low;
  logic [15:0]             src_high;
  logic [15:0]             dst_low;
  logic [15:0]             dst_high;
  logic [15:0]             match_count;
  logic [15:0]             item_count;
  logic [15:0]             progress_count;
  dmach_pkg::dmach_ctrl_t  ctrl;
  dmach_pkg::dmach_state_t state;
  logic [31:0]             held_data;
  logic                    req_d;
  logic                    fill_fetched;

  logic                    setup;
  logic                    wr_en;
  logic [DEC_IDX-1:0]      idx;
  logic                    hit;
  logic [31:0]             rd_mux;
  logic                    item_done;
  logic                    last_item;
  logic                    trig;
  logic                    ch0_wins;
  logic [31:0]             src_addr;
  logic [31:0]             dst_addr;
  logic [31:0]             src_off;
  logic [31:0]             dst_off;
  logic [15:0]             wdata16;
  logic [15:0]             ctrl_next;

  function automatic logic sel(input logic [31:0] index,
                               input logic [DEC_IDX-1:0] a);
    sel = (a == index[DEC_IDX-1:0]);
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
  assign idx   = PADDR[DEC_IDX+1:2];
  assign wdata16 = {PSTRB[1] ? PWDATA[15:8] : 8'h00,
                    PSTRB[0] ? PWDATA[7:0]  : 8'h00};

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    if (sel(dmach_pkg::IDX_CH0_PROGRESS, idx)) begin
      rd_mux = {16'h0000, CH0_PROGRESS};
    end else if (sel(dmach_pkg::IDX_SRC_START_LOW, idx)) begin
      rd_mux = {16'h0000, src_low};
    end else if (sel(dmach_pkg::IDX_SRC_START_HIGH, idx)) begin
      rd_mux = {16'h0000, src_high};
    end else if (sel(dmach_pkg::IDX_DST_START_LOW, idx)) begin
      rd_mux = {16'h0000, dst_low};
    end else if (sel(dmach_pkg::IDX_DST_START_HIGH, idx)) begin
      rd_mux = {16'h0000, dst_high};
    end else if (sel(dmach_pkg::IDX_MATCH_COUNT, idx)) begin
      rd_mux = {16'h0000, match_count};
    end else if (sel(dmach_pkg::IDX_ITEM_COUNT, idx)) begin
      rd_mux = {16'h0000, item_count};
    end else if (sel(dmach_pkg::IDX_CONTROL, idx)) begin
      rd_mux = {16'h0000, ctrl & dmach_pkg::CTRL_WMASK}; // [RL24]
    end else if (sel(dmach_pkg::IDX_PROGRESS, idx)) begin
      rd_mux = {16'h0000, progress_count};               // [RL1]
    end else begin
      hit = 1'b0;
    end
  end

  // Answer is prepared in the setup cycle so the access phase ends
  // at once; the cost is a read value one cycle old.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~hit;
      if (setup && !PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      src_low     <= dmach_pkg::RST_REG16;
      src_high    <= dmach_pkg::RST_REG16;
      dst_low     <= dmach_pkg::RST_REG16;
      dst_high    <= dmach_pkg::RST_REG16;
      match_count <= dmach_pkg::RST_REG16;
      item_count  <= dmach_pkg::RST_REG16;
    end else if (wr_en) begin
      if (sel(dmach_pkg::IDX_SRC_START_LOW, idx)) begin
        src_low <= wdata16;                              // [RL3]
      end
      if (sel(dmach_pkg::IDX_SRC_START_HIGH, idx)) begin
        src_high <= wdata16;                             // [RL3]
      end
      if (sel(dmach_pkg::IDX_DST_START_LOW, idx)) begin
        dst_low <= wdata16;                              // [RL4]
      end
      if (sel(dmach_pkg::IDX_DST_START_HIGH, idx)) begin
        dst_high <= wdata16;                             // [RL4]
      end
      if (sel(dmach_pkg::IDX_MATCH_COUNT, idx)) begin
        match_count <= wdata16;
      end
      if (sel(dmach_pkg::IDX_ITEM_COUNT, idx)) begin
        item_count <= wdata16;
      end
    end
  end

  // ****************************************************************
  // Transfer control
  // ****************************************************************
  assign item_done = (state == dmach_pkg::ST_WRITE) & BUS_READY;
  assign last_item = (progress_count == item_count);     // [RL7]

  // Rising-edge detection compares with the previous sample
  assign trig = ctrl.edge_trig ? (PERIPH_REQ & ~req_d)
                               : PERIPH_REQ;             // [RL8]

  // Equal rank goes to the lower-numbered channel
  assign ch0_wins = CH0_BUS_REQ &
                    (CH0_RANK >= ctrl.channel_rank);     // [RL14] [RL15]

  always_comb begin
    unique case (ctrl.item_size)                         // [RL21]
      dmach_pkg::SIZE_HALF: begin
        src_off = {15'h0000, progress_count, 1'b0};
      end
      dmach_pkg::SIZE_WORD: begin
        src_off = {14'h0000, progress_count, 2'h0};
      end
      default: begin
        src_off = {16'h0000, progress_count};
      end
    endcase
    dst_off = ctrl.dst_step_en ? src_off : 32'h00000000; // [RL19]
    if (!ctrl.src_step_en) begin
      src_off = 32'h00000000;                            // [RL18]
    end
  end

  assign src_addr = {src_high, src_low} + src_off;       // [RL2]
  assign dst_addr = {dst_high, dst_low} + dst_off;       // [RL2]

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      req_d <= 1'b0;
    end else begin
      req_d <= PERIPH_REQ;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= dmach_pkg::ST_IDLE;
    end else if (!ctrl.run) begin
      state <= dmach_pkg::ST_IDLE;                       // [RL22]
    end else begin
      unique case (state)
        dmach_pkg::ST_IDLE: begin
          state <= ctrl.periph_trigger ? dmach_pkg::ST_WAIT
                                       : dmach_pkg::ST_ARB; // [RL20]
        end
        dmach_pkg::ST_WAIT: begin
          if (trig) begin
            state <= dmach_pkg::ST_ARB;                  // [RL20]
          end
        end
        dmach_pkg::ST_ARB: begin
          if (!ch0_wins || BUS_LOCK) begin               // [RL10]
            if (ctrl.fill && fill_fetched) begin
              state <= dmach_pkg::ST_WRITE;              // [RL9]
            end else begin
              state <= dmach_pkg::ST_READ;               // [RL23]
            end
          end
        end
        dmach_pkg::ST_READ: begin
          if (BUS_READY) begin
            state <= dmach_pkg::ST_WRITE;                // [RL23]
          end
        end
        dmach_pkg::ST_WRITE: begin
          if (BUS_READY) begin
            if (last_item && !(ctrl.ring && ctrl.periph_trigger)) begin
              state <= dmach_pkg::ST_IDLE;               // [RL16]
            end else if (ctrl.periph_trigger) begin
              state <= dmach_pkg::ST_WAIT;               // [RL17]
            end else if (ctrl.yield) begin
              state <= dmach_pkg::ST_GAP;                // [RL13]
            end else begin
              state <= dmach_pkg::ST_ARB;                // [RL12]
            end
          end
        end
        dmach_pkg::ST_GAP: begin
          state <= dmach_pkg::ST_ARB;                    // [RL13]
        end
        default: begin
          state <= dmach_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      progress_count <= dmach_pkg::RST_REG16;
    end else if (!ctrl.run) begin
      progress_count <= dmach_pkg::RST_REG16;
    end else if (item_done) begin
      if (last_item) begin
        progress_count <= dmach_pkg::RST_REG16;          // [RL1] [RL17]
      end else begin
        progress_count <= progress_count + 16'h0001;     // [RL1]
      end
    end
  end

  // Fill data is fetched once per run; later items reuse it
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      held_data    <= 32'h00000000;
      fill_fetched <= 1'b0;
    end else begin
      if (state == dmach_pkg::ST_READ && BUS_READY) begin
        held_data    <= BUS_RDATA;                       // [RL23]
        fill_fetched <= ctrl.fill;                       // [RL9]
      end else if (!ctrl.run || (item_done && last_item)) begin
        fill_fetched <= 1'b0;
      end
    end
  end

  // Software writes win over the hardware clear of the run bit
  always_comb begin
    ctrl_next = ctrl;
    if (item_done && last_item &&
        !(ctrl.ring && ctrl.periph_trigger)) begin
      ctrl_next[dmach_pkg::BIT_RUN] = 1'b0;              // [RL16]
    end
    if (wr_en && sel(dmach_pkg::IDX_CONTROL, idx)) begin
      ctrl_next = wdata16 & dmach_pkg::CTRL_WMASK;       // [RL24]
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= dmach_pkg::RST_REG16;
    end else begin
      ctrl <= ctrl_next;
    end
  end

  // ****************************************************************
  // Bus master outputs
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      BUS_CMD <= '0;
    end else if (!ctrl.run) begin
      BUS_CMD <= '0;
    end else begin
      unique case (state)
        dmach_pkg::ST_ARB: begin
          if (!ch0_wins || BUS_LOCK) begin
            BUS_CMD.valid <= 1'b1;
            BUS_CMD.size  <= ctrl.item_size;             // [RL21]
            if (ctrl.fill && fill_fetched) begin
              BUS_CMD.write <= 1'b1;
              BUS_CMD.addr  <= dst_addr;                 // [RL9]
              BUS_CMD.wdata <= held_data;
            end else begin
              BUS_CMD.write <= 1'b0;
              BUS_CMD.addr  <= src_addr;                 // [RL23]
            end
          end
        end
        dmach_pkg::ST_READ: begin
          if (BUS_READY) begin
            BUS_CMD.write <= 1'b1;
            BUS_CMD.addr  <= dst_addr;                   // [RL23]
            BUS_CMD.wdata <= BUS_RDATA;
          end
        end
        dmach_pkg::ST_WRITE: begin
          if (BUS_READY) begin
            BUS_CMD.valid <= 1'b0;
            BUS_CMD.write <= 1'b0;
          end
        end
        default: begin
          BUS_CMD.valid <= 1'b0;
        end
      endcase
    end
  end

  // Lock is held through a fill run and through blocking copies
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      BUS_LOCK <= 1'b0;
      BUS_REQ  <= 1'b0;
    end else if (!ctrl.run || (item_done && last_item &&
                 !(ctrl.ring && ctrl.periph_trigger))) begin
      BUS_LOCK <= 1'b0;
      BUS_REQ  <= 1'b0;
    end else begin
      BUS_REQ <= (state != dmach_pkg::ST_IDLE) &&
                 (state != dmach_pkg::ST_WAIT);
      if (state == dmach_pkg::ST_ARB && (!ch0_wins || BUS_LOCK)) begin
        BUS_LOCK <= ctrl.fill |
                    (~ctrl.yield & ~ctrl.periph_trigger); // [RL10] [RL12]
      end else if (item_done && !ctrl.fill &&
                   (ctrl.yield || ctrl.periph_trigger)) begin
        BUS_LOCK <= 1'b0;                                // [RL13]
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= item_done & ctrl.irq_en &
             (match_count == progress_count);            // [RL5] [RL6]
    end
  end

endmodule

`default_nettype wire
